//--- upfc_pkg.sv
package upfc_pkg;

    // ==========================================================
    // register map
    localparam logic [7:0] ADDR_TX_BUFFER = 8'h00;
    localparam logic [7:0] ADDR_RX_BUFFER = 8'h04;
    localparam logic [7:0] ADDR_CTRL0     = 8'h08;
    localparam logic [7:0] ADDR_CTRL1     = 8'h0C;
    localparam logic [7:0] ADDR_MODE      = 8'h10;
    localparam logic [7:0] ADDR_STATUS    = 8'h14;
    localparam logic [7:0] ADDR_GPIO      = 8'h18;

    // ==========================================================
    // field positions
    localparam int CTRL0_HS_SELECT  = 0;
    localparam int CTRL0_HS_DISABLE = 1;
    localparam int CTRL1_TX_ENABLE  = 0;
    localparam int CTRL1_RX_ENABLE  = 1;
    localparam int CTRL1_DATA_INV   = 2;
    localparam int MODE_PIN_INV     = 0;
    localparam int STAT_TX_EMPTY    = 0;
    localparam int STAT_RX_FULL     = 1;
    localparam int STAT_TX_BUSY     = 2;
    localparam int STAT_HS_LEVEL    = 3;
    localparam int GPIO_OUT         = 0;
    localparam int GPIO_OE          = 1;

    // ==========================================================
    // reset values
    localparam logic [7:0] CTRL0_RESET = 8'h02;
    localparam logic [7:0] CTRL1_RESET = 8'h00;
    localparam logic [7:0] MODE_RESET  = 8'h00;

    // ==========================================================
    // timing
    localparam int FRAME_BITS      = 10;
    localparam int BIT_CYCLES_DFLT = 16;

    typedef enum logic [1:0] {UPFC_TX_IDLE, UPFC_TX_SHIFT} upfc_tx_state_t;

endpackage

//--- upfc_top.sv
// Decided for this implementation: the register offsets and register access over AHB-Lite.
`timescale 1ns/10ps

module upfc_top #(
    parameter int BIT_CYCLES = upfc_pkg::BIT_CYCLES_DFLT
) (
    // clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [7:0]  haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // serial pins
    output logic             serial_tx_pin,
    input  wire logic        serial_rx_pin,
    input  wire logic        serial_clock_pin,
    // handshake pin
    input  wire logic        handshake_pin_in,
    output logic             handshake_pin_out,
    output logic             handshake_pin_oe
);

    // ==========================================================
    // bus address phase capture
    logic       wr_pend;
    logic       rd_pend;
    logic [7:0] addr_q;
    wire        bus_take  = hsel && hready && htrans[1];
    wire        wr_tx     = wr_pend && addr_q == upfc_pkg::ADDR_TX_BUFFER;
    wire        wr_ctrl0  = wr_pend && addr_q == upfc_pkg::ADDR_CTRL0;
    wire        wr_ctrl1  = wr_pend && addr_q == upfc_pkg::ADDR_CTRL1;
    wire        wr_mode   = wr_pend && addr_q == upfc_pkg::ADDR_MODE;
    wire        wr_gpio   = wr_pend && addr_q == upfc_pkg::ADDR_GPIO;
    wire        rd_rx     = rd_pend && addr_q == upfc_pkg::ADDR_RX_BUFFER;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            rd_pend <= 1'b0;
            addr_q  <= 8'h00;
        end else begin
            wr_pend <= bus_take && hwrite;
            rd_pend <= bus_take && !hwrite;
            if (bus_take)
                addr_q <= haddr;
        end
    end

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // ==========================================================
    // registers
    logic [7:0] ctrl0_reg;
    logic [7:0] ctrl1_reg;
    logic [7:0] mode_reg;
    logic [7:0] tx_buffer_reg;
    logic [7:0] rx_buffer_reg;
    logic [1:0] gpio_reg;
    logic       tx_full;
    logic       rx_full;

    wire handshake_disable   = ctrl0_reg[upfc_pkg::CTRL0_HS_DISABLE];
    wire handshake_select    = ctrl0_reg[upfc_pkg::CTRL0_HS_SELECT];
    wire data_logic_invert   = ctrl1_reg[upfc_pkg::CTRL1_DATA_INV];
    wire pin_polarity_invert = mode_reg[upfc_pkg::MODE_PIN_INV];
    wire tx_enable           = ctrl1_reg[upfc_pkg::CTRL1_TX_ENABLE];
    wire rx_enable           = ctrl1_reg[upfc_pkg::CTRL1_RX_ENABLE];
    wire cts_mode            = !handshake_disable && !handshake_select;
    wire rts_mode            = !handshake_disable && handshake_select;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl0_reg <= upfc_pkg::CTRL0_RESET;
            ctrl1_reg <= upfc_pkg::CTRL1_RESET;
            mode_reg  <= upfc_pkg::MODE_RESET;
            gpio_reg  <= 2'b00;
        end else begin
            if (wr_ctrl0)
                ctrl0_reg <= hwdata[7:0];
            if (wr_ctrl1)
                ctrl1_reg <= hwdata[7:0];
            if (wr_mode)
                mode_reg <= hwdata[7:0];
            if (wr_gpio)
                gpio_reg <= hwdata[1:0];
        end
    end

    // ==========================================================
    // read mux
    logic       tx_busy;
    wire  [7:0] rx_read   = data_logic_invert ? ~rx_buffer_reg : rx_buffer_reg;
    wire  [7:0] status_rd = {4'h0, handshake_pin_in, tx_busy, rx_full, !tx_full};
    logic [31:0] next_rdata;

    always_comb begin
        unique case (haddr)
            upfc_pkg::ADDR_RX_BUFFER: next_rdata = {24'h00_0000, rx_read};
            upfc_pkg::ADDR_CTRL0:     next_rdata = {24'h00_0000, ctrl0_reg};
            upfc_pkg::ADDR_CTRL1:     next_rdata = {24'h00_0000, ctrl1_reg};
            upfc_pkg::ADDR_MODE:      next_rdata = {24'h00_0000, mode_reg};
            upfc_pkg::ADDR_STATUS:    next_rdata = {24'h00_0000, status_rd};
            upfc_pkg::ADDR_GPIO:      next_rdata = {30'h0000_0000, gpio_reg};
            default:                  next_rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            hrdata <= 32'h0000_0000;
        else if (bus_take && !hwrite)
            hrdata <= next_rdata;
    end

    // ==========================================================
    // bit-rate enable
    logic [15:0] baud_cnt;
    wire         baud_tick = baud_cnt == 16'(BIT_CYCLES - 1);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            baud_cnt <= 16'h0000;
        else if (baud_tick)
            baud_cnt <= 16'h0000;
        else
            baud_cnt <= baud_cnt + 16'h0001;
    end

    // ==========================================================
    // transmitter
    upfc_pkg::upfc_tx_state_t tx_state;
    logic [9:0] tx_shift;
    logic [3:0] tx_bits;
    wire        cts_ok    = !cts_mode || !handshake_pin_in;
    wire        tx_start  = tx_enable && tx_full && cts_ok && baud_tick;
    wire  [7:0] tx_word   = data_logic_invert ? ~tx_buffer_reg : tx_buffer_reg;
    wire        tx_line   = tx_state == upfc_pkg::UPFC_TX_SHIFT ? tx_shift[0] : 1'b1;

    assign tx_busy = tx_state == upfc_pkg::UPFC_TX_SHIFT;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_state      <= upfc_pkg::UPFC_TX_IDLE;
            tx_shift      <= 10'h3FF;
            tx_bits       <= 4'h0;
            tx_full       <= 1'b0;
            tx_buffer_reg <= 8'h00;
        end else begin
            if (wr_tx) begin
                tx_buffer_reg <= hwdata[7:0];
                tx_full       <= 1'b1;
            end
            unique case (tx_state)
                upfc_pkg::UPFC_TX_IDLE: begin
                    if (tx_start && !wr_tx) begin
                        tx_shift <= {1'b1, tx_word, 1'b0};
                        tx_bits  <= 4'(upfc_pkg::FRAME_BITS - 1);
                        tx_full  <= 1'b0;
                        tx_state <= upfc_pkg::UPFC_TX_SHIFT;
                    end
                end
                upfc_pkg::UPFC_TX_SHIFT: begin
                    // frame runs to its end whatever the handshake does
                    if (baud_tick) begin
                        tx_shift <= {1'b1, tx_shift[9:1]};
                        if (tx_bits == 4'h0)
                            tx_state <= upfc_pkg::UPFC_TX_IDLE;
                        else
                            tx_bits <= tx_bits - 4'h1;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            serial_tx_pin <= 1'b1;
        else
            serial_tx_pin <= tx_line ^ pin_polarity_invert;
    end

    // ==========================================================
    // receiver
    wire        rx_level  = serial_rx_pin ^ pin_polarity_invert;
    logic [8:0] rx_shift;
    logic [3:0] rx_bits;
    logic       rx_active;
    logic [15:0] rx_cnt;
    wire        rx_mid    = rx_cnt == 16'(BIT_CYCLES / 2);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_active     <= 1'b0;
            rx_cnt        <= 16'h0000;
            rx_bits       <= 4'h0;
            rx_shift      <= 9'h000;
            rx_full       <= 1'b0;
            rx_buffer_reg <= 8'h00;
        end else begin
            if (rd_rx)
                rx_full <= 1'b0;
            if (!rx_active) begin
                rx_cnt <= 16'h0000;
                if (rx_enable && !rx_level) begin
                    rx_active <= 1'b1;
                    rx_bits   <= 4'(upfc_pkg::FRAME_BITS - 1);
                end
            end else begin
                rx_cnt <= (rx_cnt == 16'(BIT_CYCLES - 1)) ? 16'h0000 : rx_cnt + 16'h0001;
                if (rx_mid) begin
                    rx_shift <= {rx_level, rx_shift[8:1]};
                    if (rx_bits == 4'h0) begin
                        rx_active     <= 1'b0;
                        rx_buffer_reg <= rx_shift[8:1];
                        rx_full       <= 1'b1;
                    end else begin
                        rx_bits <= rx_bits - 4'h1;
                    end
                end
            end
        end
    end

    // ==========================================================
    // handshake pin
    logic clk_prev;
    logic rts_level;
    wire  clk_fall  = clk_prev && !serial_clock_pin;
    wire  rx_ready  = rx_enable && !rx_full && !rx_active;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            clk_prev  <= 1'b1;
            rts_level <= 1'b1;
        end else begin
            clk_prev <= serial_clock_pin;
            if (clk_fall)
                rts_level <= 1'b1;
            else if (rx_ready)
                rts_level <= 1'b0;
        end
    end

    assign handshake_pin_out = rts_mode ? rts_level : gpio_reg[upfc_pkg::GPIO_OUT];
    assign handshake_pin_oe  = rts_mode ? 1'b1
                             : handshake_disable && gpio_reg[upfc_pkg::GPIO_OE];

    // ==========================================================
    // checks
    cts_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(tx_busy) |-> $past(!cts_mode || !handshake_pin_in))
        else $error("transmit started while clear-to-send high");
    frame_finish_a: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(tx_busy) |=> tx_busy [*2])
        else $error("frame cut short");
    rts_fall_a: assert property (@(posedge hclk) disable iff (!hresetn)
        $fell(serial_clock_pin) |=> rts_level)
        else $error("request-to-send not raised at clock fall");
    rts_low_a: assert property (@(posedge hclk) disable iff (!hresetn)
        rx_ready && !clk_fall |=> !rts_level)
        else $error("request-to-send not low when ready");
    pin_free_a: assert property (@(posedge hclk) disable iff (!hresetn)
        handshake_disable |-> handshake_pin_oe == gpio_reg[upfc_pkg::GPIO_OE]
            && handshake_pin_out == gpio_reg[upfc_pkg::GPIO_OUT])
        else $error("pin not handed to io");
    cts_input_a: assert property (@(posedge hclk) disable iff (!hresetn)
        cts_mode |-> !handshake_pin_oe)
        else $error("clear-to-send pin driven");
    rts_drive_a: assert property (@(posedge hclk) disable iff (!hresetn)
        rts_mode |-> handshake_pin_oe && handshake_pin_out == rts_level)
        else $error("request-to-send not driven");
    tx_polar_a: assert property (@(posedge hclk) disable iff (!hresetn)
        serial_tx_pin == ($past(tx_line) ^ $past(pin_polarity_invert)))
        else $error("transmit pin polarity wrong");
    tx_invert_a: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(tx_busy) |-> tx_shift[8:1] == ($past(data_logic_invert) ? ~$past(tx_buffer_reg) : $past(tx_buffer_reg)))
        else $error("transmit data inversion wrong");
    rx_invert_a: assert property (@(posedge hclk) disable iff (!hresetn)
        rd_rx |-> hrdata[7:0] == $past(data_logic_invert ? ~rx_buffer_reg : rx_buffer_reg))
        else $error("receive data inversion wrong");

    tx_frame_c: cover property (@(posedge hclk) disable iff (!hresetn) $fell(tx_busy));
    rx_frame_c: cover property (@(posedge hclk) disable iff (!hresetn) $rose(rx_full));
    cts_hold_c: cover property (@(posedge hclk) disable iff (!hresetn) cts_mode && tx_full && handshake_pin_in);
    rts_cycle_c: cover property (@(posedge hclk) disable iff (!hresetn) rts_mode && clk_fall && !rts_level);

endmodule // upfc_top

//--- upfc_peer.sv
`timescale 1ns/10ps

// ==========================================================
// remote serial peer with hardware handshake
module upfc_peer #(
    parameter int BIT_CYCLES = 4
) (
    // clock
    input  wire logic hclk,
    // serial lines
    input  wire logic serial_tx_pin,
    output logic      serial_rx_pin,
    output logic      serial_clock_pin,
    // handshake drive
    output logic      cts_level
);
    initial begin
        serial_rx_pin = 1'b1;
        serial_clock_pin = 1'b1;
        cts_level = 1'b1;
    end

    // idle line level and permission to send
    task automatic set_line(input logic pol, input logic cts);
        serial_rx_pin <= ~pol;
        cts_level <= cts;
    endtask

    // one frame onto the receive line, clock low in first half of each bit
    task automatic send_frame(input logic pol, input logic [7:0] d);
        logic [9:0] f;
        f = {1'b1, d, 1'b0};
        for (int i = 0; i < 10; i++) begin
            serial_rx_pin <= f[i] ^ pol;
            serial_clock_pin <= 1'b0;
            repeat (BIT_CYCLES / 2) @(posedge hclk);
            serial_clock_pin <= 1'b1;
            repeat (BIT_CYCLES - BIT_CYCLES / 2) @(posedge hclk);
        end
    endtask

    // one frame from the transmit line, sampled mid-bit
    task automatic recv_frame(input logic pol, input int limit, output logic [7:0] d, output logic ok);
        int n;
        d = 8'h00;
        ok = 1'b0;
        n = 0;
        while (serial_tx_pin !== pol && n < limit) begin
            @(posedge hclk);
            n++;
        end
        if (n >= limit) return;
        repeat (BIT_CYCLES / 2) @(posedge hclk);
        ok = (serial_tx_pin === pol);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT_CYCLES) @(posedge hclk);
            d[i] = serial_tx_pin ^ pol;
        end
        repeat (BIT_CYCLES) @(posedge hclk);
        ok = ok && (serial_tx_pin === ~pol);
    endtask
endmodule // upfc_peer

//--- tb_uart_polarity_flow_control.sv
`timescale 1ns/10ps

module tb_uart_polarity_flow_control;
    localparam int BITC = 4;

    // ==========================================================
    // signals
    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic [7:0]  haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        tx;
    logic        rx;
    logic        sclk;
    logic        hs_out;
    logic        hs_oe;
    logic        cts_level;
    logic        hs_wire;
    int          num_errors = 0;
    int          checked = 0;

    assign hs_wire = hs_oe ? hs_out : cts_level;

    upfc_top #(.BIT_CYCLES(BITC)) upfc_top_inst (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .serial_tx_pin(tx), .serial_rx_pin(rx), .serial_clock_pin(sclk),
        .handshake_pin_in(hs_wire), .handshake_pin_out(hs_out), .handshake_pin_oe(hs_oe)
    );

    upfc_peer #(.BIT_CYCLES(BITC)) upfc_peer_inst (
        .hclk(hclk), .serial_tx_pin(tx), .serial_rx_pin(rx), .serial_clock_pin(sclk),
        .cts_level(cts_level)
    );

    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end

    // ==========================================================
    // shared tasks
    task automatic wrap_up();
        if (num_errors == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
        int n;
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= wr;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 100);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 100);
        rd = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask

    task automatic cfg(input logic [7:0] c0, input logic [7:0] c1, input logic pinv, input logic cts);
        wr(upfc_pkg::ADDR_CTRL1, 32'h0000_0000);
        wr(upfc_pkg::ADDR_CTRL0, {24'h00_0000, c0});
        wr(upfc_pkg::ADDR_MODE, {31'h0000_0000, pinv});
        upfc_peer_inst.set_line(pinv, cts);
        repeat (2 * BITC) @(posedge hclk);
        wr(upfc_pkg::ADDR_CTRL1, {24'h00_0000, c1});
    endtask

    // ==========================================================
    // scenarios
    task automatic t_regs();
        logic [31:0] r;
        bus(1'b0, upfc_pkg::ADDR_CTRL0, 32'h0, r);
        check("ctrl0 reset", {24'h00_0000, upfc_pkg::CTRL0_RESET}, r);
        bus(1'b0, upfc_pkg::ADDR_MODE, 32'h0, r);
        check("mode reset", {24'h00_0000, upfc_pkg::MODE_RESET}, r);
        wr(8'h1C, 32'hFFFF_FFFF);
        bus(1'b0, 8'h1C, 32'h0, r);
        check("unmapped read", 32'h0, r);
        check("response", 32'h0, {31'h0, hresp});
        check("ready", 32'h1, {31'h0, hreadyout});
        @(negedge hclk);
        check("tx idle", 32'h1, {31'h0, tx});
        check("pin released", 32'h0, {31'h0, hs_oe});
    endtask

    task automatic t_gpio();
        logic [7:0]  d;
        logic        ok;
        logic [31:0] r;
        cfg(8'h02, 8'h01, 1'b0, 1'b1);
        wr(upfc_pkg::ADDR_GPIO, 32'h0000_0003);
        @(negedge hclk);
        check("gpio drive", 32'h3, {30'h0, hs_oe, hs_out});
        bus(1'b0, upfc_pkg::ADDR_GPIO, 32'h0, r);
        check("gpio readback", 32'h3, r);
        wr(upfc_pkg::ADDR_GPIO, 32'h0000_0002);
        @(negedge hclk);
        check("gpio low", 32'h2, {30'h0, hs_oe, hs_out});
        wr(upfc_pkg::ADDR_GPIO, 32'h0000_0000);
        wr(upfc_pkg::ADDR_TX_BUFFER, 32'h0000_00A5);
        upfc_peer_inst.recv_frame(1'b0, 12 * BITC, d, ok);
        check("ungated frame", 32'h1A5, {23'h0, ok, d});
    endtask

    task automatic t_tx();
        logic [7:0] d;
        logic       ok;
        for (int k = 0; k < 4; k++) begin
            cfg(8'h00, {5'h00, k[0], 2'b01}, k[1], 1'b0);
            wr(upfc_pkg::ADDR_TX_BUFFER, {24'h00_0000, 8'h96 ^ 8'(k)});
            upfc_peer_inst.recv_frame(k[1], 12 * BITC, d, ok);
            check("tx frame", {23'h0, 1'b1, 8'h96 ^ 8'(k) ^ {8{k[0]}}}, {23'h0, ok, d});
            repeat (BITC) @(posedge hclk);
            check("tx idle level", {31'h0, ~k[1]}, {31'h0, tx});
        end
    endtask

    task automatic t_rx();
        logic [31:0] r;
        for (int k = 0; k < 4; k++) begin
            cfg(8'h02, {5'h00, k[0], 2'b10}, k[1], 1'b0);
            upfc_peer_inst.send_frame(k[1], 8'h4B ^ 8'(k << 4));
            repeat (3 * BITC) @(posedge hclk);
            bus(1'b0, upfc_pkg::ADDR_RX_BUFFER, 32'h0, r);
            check("rx word", {24'h0, 8'h4B ^ 8'(k << 4) ^ {8{k[0]}}}, r);
        end
    endtask

    task automatic t_cts();
        logic [7:0]  d;
        logic        ok;
        logic [31:0] r;
        cfg(8'h00, 8'h01, 1'b0, 1'b1);
        wr(upfc_pkg::ADDR_TX_BUFFER, 32'h0000_005A);
        upfc_peer_inst.recv_frame(1'b0, 12 * BITC, d, ok);
        check("held by handshake", 32'h0, {31'h0, ok});
        bus(1'b0, upfc_pkg::ADDR_STATUS, 32'h0, r);
        check("status held", 32'h0000_0001 << upfc_pkg::STAT_HS_LEVEL, r);
        upfc_peer_inst.set_line(1'b0, 1'b0);
        upfc_peer_inst.recv_frame(1'b0, 12 * BITC, d, ok);
        check("released frame", 32'h15A, {23'h0, ok, d});
        wr(upfc_pkg::ADDR_TX_BUFFER, 32'h0000_00C3);
        fork
            upfc_peer_inst.recv_frame(1'b0, 12 * BITC, d, ok);
            begin
                wait (tx === 1'b0);
                @(posedge hclk);
                upfc_peer_inst.set_line(1'b0, 1'b1);
            end
        join
        check("frame finished", 32'h1C3, {23'h0, ok, d});
        wr(upfc_pkg::ADDR_TX_BUFFER, 32'h0000_0011);
        upfc_peer_inst.recv_frame(1'b0, 12 * BITC, d, ok);
        check("suspended", 32'h0, {31'h0, ok});
        upfc_peer_inst.set_line(1'b0, 1'b0);
        upfc_peer_inst.recv_frame(1'b0, 12 * BITC, d, ok);
        check("resumed", 32'h111, {23'h0, ok, d});
    endtask

    task automatic t_rts();
        logic [31:0] r;
        logic        saw;
        cfg(8'h01, 8'h02, 1'b0, 1'b1);
        @(posedge hclk);
        @(negedge hclk);
        check("rts ready", 32'h2, {30'h0, hs_oe, hs_out});
        @(posedge hclk);
        saw = 1'b0;
        fork
            upfc_peer_inst.send_frame(1'b0, 8'h77);
            repeat (6) begin
                @(posedge hclk);
                #1 saw = saw | hs_out;
            end
        join
        check("rts at clock fall", 32'h1, {31'h0, saw});
        repeat (3 * BITC) @(posedge hclk);
        check("rts while full", 32'h1, {31'h0, hs_out});
        bus(1'b0, upfc_pkg::ADDR_RX_BUFFER, 32'h0, r);
        check("rts frame data", 32'h77, r);
        repeat (2) @(posedge hclk);
        @(negedge hclk);
        check("rts ready again", 32'h0, {31'h0, hs_out});
    endtask

    // ==========================================================
    // main sequence and watchdog
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 8'h00;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0000_0000;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        t_regs();
        t_gpio();
        t_tx();
        t_rx();
        t_cts();
        t_rts();
        wrap_up();
    end

    initial begin
        repeat (20000) @(posedge hclk);
        num_errors++;
        wrap_up();
    end
endmodule // tb_uart_polarity_flow_control
